// [srp_ctrl_model.sv]
// model: memory controller driving clock, clock enable and command pins
`timescale 1ns/1ps
module srp_ctrl_model (
    input wire logic clk_i,
    output logic ck_o,
    output logic cke_o,
    output logic cs_n_o,
    output logic [9:0] ca_o
);
    // idle pins, clock stopped low
    initial begin
        ck_o = 1'b0;
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        ca_o = 10'h155;
    end
    // one memory clock period of four internal clocks, pins changed at falling edge
    task automatic cyc(input logic cke, input logic cs_n, input logic [9:0] ca);
        @(negedge clk_i);
        cke_o = cke;
        cs_n_o = cs_n;
        ca_o = ca;
        ck_o = 1'b1;
        repeat (2) @(negedge clk_i);
        ck_o = 1'b0;
        @(negedge clk_i);
    endtask
    // deselect, address lines keep changing
    task automatic nop(input logic cke);
        cyc(cke, 1'b1, ~ca_o);
    endtask
    task automatic mode_write(input logic [5:0] addr, input logic [7:0] data);
        cyc(1'b1, 1'b0, {addr, 4'h0});
        cyc(1'b1, 1'b0, {data, 2'b00});
    endtask
    task automatic refresh_all();
        cyc(1'b1, 1'b0, 10'h00c);
    endtask
    // banks are never opened by this model, so entry always finds them idle
    task automatic enter();
        nop(1'b1);
        cyc(1'b0, 1'b0, 10'h004);
        nop(1'b0);
    endtask
    // clock stopped, cke held low, other pins toggled as garbage
    task automatic stay(input int n);
        repeat (n) begin
            @(negedge clk_i);
            cs_n_o = ~cs_n_o;
            ca_o = ~ca_o;
        end
    endtask
    task automatic leave();
        repeat (2) nop(1'b0);
        repeat (3) nop(1'b1);
    endtask
endmodule

// [srp_pkg.sv]
// package: constants, commands and helpers of the self refresh and partial array retention block
package srp_pkg;
    // mode register addresses
    localparam logic [7:0] MA_BANK_MASK = 8'h10;
    localparam logic [7:0] MA_SEG_MASK = 8'h11;
    // reset values of the mask registers (all unmasked)
    localparam logic [7:0] BANK_MASK_RST = 8'h00;
    localparam logic [7:0] SEG_MASK_RST = 8'h00;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int REF_INT_NS = 3900;
    localparam int REF_INT_CYC = REF_INT_NS * CLK_MHZ / 1000;
    localparam int DWELL_CYC = 32'd300;
    localparam int XSR_CYC = 32'd12;
    // error flag positions
    localparam int ERR_PRE_CKE = 0;
    localparam int ERR_POST_NOP = 1;
    localparam int ERR_EARLY_EXIT = 2;
    localparam int ERR_EXIT_SEQ = 3;
    localparam int ERR_NO_REFRESH = 4;
    localparam int ERR_W = 5;
    // per-bank refreshes that stand in for one all-bank refresh
    localparam logic [3:0] PB_REF_COUNT = 4'h8;

    // NOP: deselect, or selected with CA[2:0] all high
    function automatic logic is_nop(input logic cs_n, input logic [9:0] ca);
        is_nop = cs_n | (ca[2:0] == 3'h7);
    endfunction

    // CA0 low, CA1 low, CA2 high: self refresh entry with CKE low, refresh with CKE high
    function automatic logic is_l_l_h(input logic cs_n, input logic [9:0] ca);
        is_l_l_h = ~cs_n & (ca[2:0] == 3'h4);
    endfunction
endpackage

// [srp_refresh_engine.sv]
// module: internal refresh timer that walks segments while self refresh runs
`timescale 1ns/1ps
module srp_refresh_engine #(
    parameter int REF_INT = srp_pkg::REF_INT_CYC,
    parameter bit LARGE_DENSITY = 1'b1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    srp_refresh_if.eng rif
);
    logic [15:0] timer_reg;
    logic [2:0] seg_reg;
    logic [15:0] interval;
    logic [7:0] bank_live;
    logic seg_live;

    // cool parts refresh at half rate to save power
    always_comb begin
        interval = rif.temp_high ? 16'(REF_INT) : 16'(2 * REF_INT);
    end

    // banks that exist and are unmasked; a 1 bit means masked
    always_comb begin
        bank_live = ~rif.bank_mask;
        if (!LARGE_DENSITY) begin
            bank_live[7:4] = 4'h0;
        end
    end

    // segment gating applies to every bank alike
    always_comb begin
        seg_live = LARGE_DENSITY ? ~rif.seg_mask[seg_reg] : 1'b1;
    end

    // timer: first refresh fires on the first cycle of a run
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_reg <= 16'h0000;
        end else if (!rif.run) begin
            timer_reg <= 16'h0000;
        end else if (timer_reg == 16'h0000) begin
            timer_reg <= interval - 16'h0001;
        end else begin
            timer_reg <= timer_reg - 16'h0001;
        end
    end

    // segment walk and refresh pulse
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seg_reg <= 3'h0;
            rif.pulse <= 1'b0;
            rif.banks <= 8'h00;
            rif.segment <= 3'h0;
        end else begin
            rif.pulse <= 1'b0;
            if (!rif.run) begin
                seg_reg <= 3'h0;
            end else if (timer_reg == 16'h0000) begin
                seg_reg <= seg_reg + 3'h1;
                rif.segment <= seg_reg;
                rif.banks <= seg_live ? bank_live : 8'h00;
                rif.pulse <= seg_live & (|bank_live);
            end
        end
    end
endmodule

// [srp_refresh_if.sv]
// interface: link between the sequencer and the internal refresh engine
`timescale 1ns/1ps
interface srp_refresh_if;
    logic run;
    logic temp_high;
    logic [7:0] bank_mask;
    logic [7:0] seg_mask;
    logic pulse;
    logic [7:0] banks;
    logic [2:0] segment;

    modport seq (output run, temp_high, bank_mask, seg_mask, input pulse, banks, segment);
    modport eng (input run, temp_high, bank_mask, seg_mask, output pulse, banks, segment);
endinterface

// [srp_self_refresh.sv]
// module: self refresh entry, residency and exit sequencer with mask registers
`timescale 1ns/1ps
module srp_self_refresh #(
    parameter int DWELL = srp_pkg::DWELL_CYC,
    parameter int XSR = srp_pkg::XSR_CYC,
    parameter int REF_INT = srp_pkg::REF_INT_CYC,
    parameter bit LARGE_DENSITY = 1'b1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ck_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic [9:0] ca_i,
    input wire logic temp_high_i,
    output logic self_refresh_o,
    output logic core_clk_en_o,
    output logic cmd_ready_o,
    output logic [srp_pkg::ERR_W-1:0] protocol_err_o,
    output logic refresh_pulse_o,
    output logic [7:0] refresh_banks_o,
    output logic [2:0] refresh_segment_o,
    output logic [7:0] bank_refresh_mask_o,
    output logic [7:0] segment_refresh_mask_o
);
    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_ENTRY_NOP,
        ST_SELF_REF,
        ST_EXIT_WAIT,
        ST_EXIT_XSR
    } srp_state_t;

    srp_state_t state_reg;
    srp_state_t state_next;

    // pin synchronisers: {temp, ck, cke, cs_n, ca}
    logic [13:0] sync1_reg;
    logic [13:0] sync2_reg;
    logic ck_prev_reg;
    logic ck_rise;
    logic cke_s;
    logic cs_n_s;
    logic [9:0] ca_s;
    logic temp_s;

    logic cke_prev_reg;
    logic [15:0] dwell_cnt_reg;
    logic dwell_met;
    logic [15:0] xsr_cnt_reg;
    logic [7:0] bank_mask_reg;
    logic [7:0] seg_mask_reg;
    logic mrw_pend_reg;
    logic [7:0] mrw_addr_reg;
    logic refreshed_reg;
    logic [3:0] pb_cnt_reg;
    logic [srp_pkg::ERR_W-1:0] err_reg;
    logic self_ref_reg;
    logic clk_en_reg;
    logic ready_reg;
    logic entry_cmd;
    logic cmd_nop;
    logic ref_cmd;

    srp_refresh_if rif ();

    // two flip-flops on every pin before use
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg <= 14'h0000;
            sync2_reg <= 14'h0000;
        end else begin
            sync1_reg <= {temp_high_i, ck_i, cke_i, cs_n_i, ca_i};
            sync2_reg <= sync1_reg;
        end
    end

    // synchronised pin names
    assign temp_s = sync2_reg[13];
    assign cke_s = sync2_reg[11];
    assign cs_n_s = sync2_reg[10];
    assign ca_s = sync2_reg[9:0];

    // external clock edge detect on the synchronised copy
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ck_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg <= sync2_reg[12];
        end
    end

    assign ck_rise = sync2_reg[12] & ~ck_prev_reg;

    // command decode at a clock rise
    assign cmd_nop = srp_pkg::is_nop(cs_n_s, ca_s);
    assign entry_cmd = ~cke_s & srp_pkg::is_l_l_h(cs_n_s, ca_s);
    assign ref_cmd = cke_s & srp_pkg::is_l_l_h(cs_n_s, ca_s);

    // cke level held at the previous clock rise
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cke_prev_reg <= 1'b1;
        end else if (ck_rise) begin
            cke_prev_reg <= cke_s;
        end
    end

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ACTIVE: begin
                if (ck_rise && entry_cmd) begin
                    state_next = ST_ENTRY_NOP;
                end
            end
            ST_ENTRY_NOP: begin
                if (ck_rise) begin
                    state_next = ST_SELF_REF;
                end
            end
            ST_SELF_REF: begin
                // only cke is watched here; clock may be stopped
                if (cke_s) begin
                    state_next = ST_EXIT_WAIT;
                end
            end
            ST_EXIT_WAIT: begin
                if (!cke_s) begin
                    state_next = ST_SELF_REF;
                end else if (ck_rise) begin
                    state_next = ST_EXIT_XSR;
                end
            end
            ST_EXIT_XSR: begin
                if (xsr_cnt_reg == 16'h0000) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_ACTIVE;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    // residency counter, saturates once the dwell is met
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dwell_cnt_reg <= 16'h0000;
        end else if (state_reg == ST_ACTIVE) begin
            dwell_cnt_reg <= 16'h0000;
        end else if (!dwell_met) begin
            dwell_cnt_reg <= dwell_cnt_reg + 16'h0001;
        end
    end

    assign dwell_met = dwell_cnt_reg >= 16'(DWELL);

    // exit interval countdown from the first clock rise after the cycle in which cke is first seen high
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xsr_cnt_reg <= 16'h0000;
        end else if (state_reg == ST_EXIT_WAIT) begin
            xsr_cnt_reg <= 16'(XSR - 1);
        end else if (state_reg == ST_EXIT_XSR && xsr_cnt_reg != 16'h0000) begin
            xsr_cnt_reg <= xsr_cnt_reg - 16'h0001;
        end
    end

    // mode register write: address beat then data beat on ca[9:2]
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mrw_pend_reg <= 1'b0;
            mrw_addr_reg <= 8'h00;
        end else if (state_reg != ST_ACTIVE || !ready_reg) begin
            mrw_pend_reg <= 1'b0;
        end else if (ck_rise) begin
            if (mrw_pend_reg) begin
                mrw_pend_reg <= 1'b0;
            end else if (cke_s && !cs_n_s && ca_s[3:0] == 4'h0) begin
                mrw_pend_reg <= 1'b1;
                mrw_addr_reg <= {2'b00, ca_s[9:4]};
            end
        end
    end

    // mask registers, 1 masks a bank or segment
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bank_mask_reg <= srp_pkg::BANK_MASK_RST;
            seg_mask_reg <= srp_pkg::SEG_MASK_RST;
        end else if (ck_rise && mrw_pend_reg && state_reg == ST_ACTIVE) begin
            if (mrw_addr_reg == srp_pkg::MA_BANK_MASK) begin
                bank_mask_reg <= ca_s[9:2];
            end else if (mrw_addr_reg == srp_pkg::MA_SEG_MASK) begin
                seg_mask_reg <= ca_s[9:2];
            end
        end
    end

    // refresh owed since the last exit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            refreshed_reg <= 1'b1;
            pb_cnt_reg <= 4'h0;
        end else if (state_reg == ST_EXIT_XSR && state_next == ST_ACTIVE) begin
            refreshed_reg <= 1'b0;
            pb_cnt_reg <= 4'h0;
        end else if (state_reg == ST_ACTIVE && ready_reg && ck_rise && ref_cmd) begin
            if (ca_s[3]) begin
                refreshed_reg <= 1'b1;
            end else if (pb_cnt_reg == srp_pkg::PB_REF_COUNT - 4'h1) begin
                refreshed_reg <= 1'b1;
            end else begin
                pb_cnt_reg <= pb_cnt_reg + 4'h1;
            end
        end
    end

    // sticky protocol error flags, cleared only by reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            err_reg <= '0;
        end else begin
            if (state_reg == ST_ACTIVE && ck_rise && entry_cmd) begin
                if (!cke_prev_reg) begin
                    err_reg[srp_pkg::ERR_PRE_CKE] <= 1'b1;
                end
                if (!refreshed_reg) begin
                    err_reg[srp_pkg::ERR_NO_REFRESH] <= 1'b1;
                end
            end
            if (state_reg == ST_ENTRY_NOP && ck_rise && !cmd_nop) begin
                err_reg[srp_pkg::ERR_POST_NOP] <= 1'b1;
            end
            if (state_reg == ST_SELF_REF && cke_s && !dwell_met) begin
                err_reg[srp_pkg::ERR_EARLY_EXIT] <= 1'b1;
            end
            if (state_reg == ST_EXIT_XSR && ck_rise && (!cke_s || !cmd_nop)) begin
                err_reg[srp_pkg::ERR_EXIT_SEQ] <= 1'b1;
            end
        end
    end

    // status flags: residency, clock gate and command acceptance
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            self_ref_reg <= 1'b0;
            clk_en_reg <= 1'b1;
            ready_reg <= 1'b1;
        end else begin
            self_ref_reg <= state_next != ST_ACTIVE;
            clk_en_reg <= state_next == ST_ACTIVE || state_next == ST_EXIT_XSR;
            ready_reg <= state_next == ST_ACTIVE;
        end
    end

    // engine runs from entry until the exit interval ends
    assign rif.run = state_reg != ST_ACTIVE;
    assign rif.temp_high = temp_s;
    assign rif.bank_mask = bank_mask_reg;
    assign rif.seg_mask = seg_mask_reg;

    srp_refresh_engine #(
        .REF_INT(REF_INT),
        .LARGE_DENSITY(LARGE_DENSITY)
    ) u_engine (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .rif(rif)
    );

    // outputs, each from a flip-flop
    assign self_refresh_o = self_ref_reg;
    assign core_clk_en_o = clk_en_reg;
    assign cmd_ready_o = ready_reg;
    assign protocol_err_o = err_reg;
    assign refresh_pulse_o = rif.pulse;
    assign refresh_banks_o = rif.banks;
    assign refresh_segment_o = rif.segment;
    assign bank_refresh_mask_o = bank_mask_reg;
    assign segment_refresh_mask_o = seg_mask_reg;
endmodule

// [srp_self_refresh_properties.sv]
// checker: concurrent properties on the self refresh block ports
`timescale 1ns/1ps
module srp_self_refresh_properties #(
    parameter int DWELL = srp_pkg::DWELL_CYC,
    parameter int XSR = srp_pkg::XSR_CYC,
    parameter int REF_INT = srp_pkg::REF_INT_CYC,
    parameter bit LARGE_DENSITY = 1'b1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ck_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic [9:0] ca_i,
    input wire logic temp_high_i,
    input wire logic self_refresh_o,
    input wire logic core_clk_en_o,
    input wire logic cmd_ready_o,
    input wire logic [srp_pkg::ERR_W-1:0] protocol_err_o,
    input wire logic refresh_pulse_o,
    input wire logic [7:0] refresh_banks_o,
    input wire logic [2:0] refresh_segment_o,
    input wire logic [7:0] bank_refresh_mask_o,
    input wire logic [7:0] segment_refresh_mask_o
);
    localparam int XSR_M1 = XSR - 1;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // refresh pulses are single cycles and only come from the internal timer
    property p_pulse_single;
        refresh_pulse_o |=> !refresh_pulse_o;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("refresh pulse longer than one cycle");
    property p_pulse_in_sr;
        refresh_pulse_o |-> self_refresh_o || $past(self_refresh_o);
    endproperty
    a_pulse_in_sr: assert property (p_pulse_in_sr) else $error("internal refresh outside self refresh");
    // masked banks and segments never refreshed
    property p_bank_mask;
        refresh_pulse_o |-> refresh_banks_o == ~bank_refresh_mask_o;
    endproperty
    a_bank_mask: assert property (p_bank_mask) else $error("refreshed banks disagree with bank mask");
    property p_seg_mask;
        refresh_pulse_o |-> !segment_refresh_mask_o[refresh_segment_o];
    endproperty
    a_seg_mask: assert property (p_seg_mask) else $error("masked segment refreshed");
    // clock gate and command acceptance follow the residency
    property p_gate_off;
        !core_clk_en_o |-> self_refresh_o && !cmd_ready_o;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("clock gated outside self refresh");
    property p_exit_ready;
        $fell(self_refresh_o) |-> cmd_ready_o && core_clk_en_o;
    endproperty
    a_exit_ready: assert property (p_exit_ready) else $error("not ready after exit interval");
    // first internal refresh lands within the dwell
    property p_first_ref;
        $rose(self_refresh_o) && !segment_refresh_mask_o[0] && bank_refresh_mask_o != 8'hff
            |-> ##[1:DWELL] refresh_pulse_o;
    endproperty
    a_first_ref: assert property (p_first_ref) else $error("no refresh within dwell");
    // exit interval lasts exactly XSR cycles after the clock gate opens
    property p_xsr;
        $rose(core_clk_en_o) |-> self_refresh_o ##[XSR_M1:XSR_M1] self_refresh_o ##1 !self_refresh_o;
    endproperty
    a_xsr: assert property (p_xsr) else $error("exit interval length wrong");
endmodule

bind srp_self_refresh srp_self_refresh_properties #(.DWELL(DWELL), .XSR(XSR), .REF_INT(REF_INT),
    .LARGE_DENSITY(LARGE_DENSITY)) props_i (.clk_i(clk_i), .rstn_i(rstn_i), .ck_i(ck_i), .cke_i(cke_i),
    .cs_n_i(cs_n_i), .ca_i(ca_i), .temp_high_i(temp_high_i), .self_refresh_o(self_refresh_o),
    .core_clk_en_o(core_clk_en_o), .cmd_ready_o(cmd_ready_o), .protocol_err_o(protocol_err_o),
    .refresh_pulse_o(refresh_pulse_o), .refresh_banks_o(refresh_banks_o), .refresh_segment_o(refresh_segment_o),
    .bank_refresh_mask_o(bank_refresh_mask_o), .segment_refresh_mask_o(segment_refresh_mask_o));

// [test_srp_self_refresh.sv]
// testbench: self refresh sequencing and partial array retention masking
`timescale 1ns/1ps
module test_srp_self_refresh;
    localparam int REF_INT = 8;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic temp_high_i = 1'b1;
    logic ck, cke, cs_n, sr, gate, ready, pulse;
    logic [9:0] ca;
    logic [4:0] err;
    logic [7:0] banks, bmask, smask;
    logic [2:0] seg;
    logic [7:0] seg_seen = 8'h00;
    logic [2:0] last_seg = 3'h0;
    time last_t = 0;
    int gap = 0;
    int pulses = 0;
    int bank_bad = 0;
    int err_total = 0;
    int tests_run = 0;

    always #10 clk_i = ~clk_i;

    srp_ctrl_model srp_ctrl_model_i (.clk_i(clk_i), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca));
    srp_self_refresh #(.DWELL(20), .XSR(4), .REF_INT(REF_INT), .LARGE_DENSITY(1'b1)) srp_self_refresh_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .ca_i(ca),
        .temp_high_i(temp_high_i), .self_refresh_o(sr), .core_clk_en_o(gate), .cmd_ready_o(ready),
        .protocol_err_o(err), .refresh_pulse_o(pulse), .refresh_banks_o(banks), .refresh_segment_o(seg),
        .bank_refresh_mask_o(bmask), .segment_refresh_mask_o(smask));

    // pulse monitor: segments seen and spacing from segment 0 to segment 1
    always @(negedge clk_i) begin
        if (pulse === 1'b1) begin
            pulses++;
            // banks 1 and 7 are masked for the whole run, so every pulse must name the other six
            if (banks !== 8'h7d) bank_bad++;
            seg_seen[seg] = 1'b1;
            if (seg === 3'h1 && last_seg === 3'h0) gap = int'(($time - last_t) / 20);
            last_seg = seg;
            last_t = $time;
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic status(input logic s, input logic g, input logic r, input logic [4:0] e);
        repeat (4) @(negedge clk_i);
        chk("self_refresh", {7'h0, s}, {7'h0, sr});
        chk("core_clk_en", {7'h0, g}, {7'h0, gate});
        chk("cmd_ready", {7'h0, r}, {7'h0, ready});
        chk("protocol_err", {3'h0, e}, {3'h0, err});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 700 cycles the sequence needs
    initial begin
        #400000;
        err_total++;
        $display("Error watchdog expected done seen timeout");
        end_of_test();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        status(1'b0, 1'b1, 1'b1, 5'h00);
        chk("bank_mask", 8'h00, bmask);
        $display("test reset done");
        srp_ctrl_model_i.mode_write(6'h10, 8'h82);
        srp_ctrl_model_i.mode_write(6'h11, 8'h84);
        srp_ctrl_model_i.mode_write(6'h12, 8'hff);
        repeat (4) @(negedge clk_i);
        chk("bank_mask", 8'h82, bmask);
        chk("seg_mask", 8'h84, smask);
        $display("test mask write done");
        srp_ctrl_model_i.refresh_all();
        srp_ctrl_model_i.enter();
        status(1'b1, 1'b0, 1'b0, 5'h00);
        seg_seen = 8'h00;
        srp_ctrl_model_i.stay(16 * REF_INT + 10);
        chk("segments", 8'h7b, seg_seen);
        chk("hot_gap", REF_INT[7:0], gap[7:0]);
        temp_high_i = 1'b0;
        gap = 0;
        srp_ctrl_model_i.stay(32 * REF_INT + 10);
        chk("cool_gap", 8'(2 * REF_INT), gap[7:0]);
        chk("pulsed", 8'h01, {7'h0, pulses > 0});
        chk("banks_masked", 8'h00, bank_bad[7:0]);
        chk("mask_kept", 8'h82, bmask);
        srp_ctrl_model_i.leave();
        status(1'b0, 1'b1, 1'b1, 5'h00);
        $display("test residency done");
        srp_ctrl_model_i.refresh_all();
        srp_ctrl_model_i.enter();
        srp_ctrl_model_i.stay(1);
        srp_ctrl_model_i.leave();
        status(1'b0, 1'b1, 1'b1, 5'h04);
        $display("test early exit done");
        srp_ctrl_model_i.enter();
        srp_ctrl_model_i.stay(40);
        srp_ctrl_model_i.leave();
        status(1'b0, 1'b1, 1'b1, 5'h14);
        $display("test entry without refresh done");
        // cke low at the rise before entry, a command after entry, a refresh inside the exit interval
        srp_ctrl_model_i.nop(1'b0);
        srp_ctrl_model_i.cyc(1'b0, 1'b0, 10'h004);
        srp_ctrl_model_i.cyc(1'b0, 1'b0, 10'h004);
        srp_ctrl_model_i.stay(40);
        repeat (2) srp_ctrl_model_i.nop(1'b0);
        repeat (2) srp_ctrl_model_i.nop(1'b1);
        srp_ctrl_model_i.cyc(1'b1, 1'b0, 10'h00c);
        status(1'b0, 1'b1, 1'b1, 5'h1f);
        $display("test protocol violations done");
        end_of_test();
    end
endmodule
